// *** hw/sba_sym_agent.sv ***
// symmetric agent end: identity capture, rotating priority and stall handling
//
// Function
// - full queue asserts stall; owner stops issuing
// - stall line wired-or, driven/sampled alternate edges
// - priority request stops new unlocked requests
// - priority agent holds request until done
// - four agents: line i on pin i-k
// - two agents use lines 0,1 only
// - priority agent asserts line 0 at reset
// - identity taken from pins at reset release
// - agent n drives only line n
// - rotating id starts at three
// - rotating id follows each new owner
// - event: idle assert or owner release
// - all agents pick same round-robin owner
// - owner parks while nobody else requests
// - owner drops request when others request
// - bus init restores rotating id, clears bus tracking state, keeps identity
`timescale 1ns/1ps
module sba_sym_agent #(
    parameter bit PARK = 1'b1
) (
    input  wire logic       mclk,
    input  wire logic       reset,
    sba_if.sym_mp           bus,
    input  wire logic       bus_init_signal_enable,
    input  wire logic       user_req,
    input  wire logic       user_locked,
    input  wire logic       queue_full,
    output logic            id_valid,
    output logic [1:0]      arb_id,
    output logic [2:0]      reported_id,
    output logic [1:0]      rot_id,
    output logic            is_owner,
    output logic            stall,
    output logic            issue_ok
);

    // all state in one packed word
    typedef struct packed {
        logic       id_valid;
        logic [1:0] arb_id;
        logic [1:0] rot_id;
        logic       owner_valid;
        logic [1:0] owner;
        logic       req;
        logic       hold;
        logic [3:0] prev_lines;
        logic       phase;
        logic       bnr_drive;
        logic       stall;
    } sba_sym_state_t;

    // values after reset; identity comes back invalid
    localparam sba_sym_state_t SBA_SYM_RESET = '{
        id_valid:    1'b0,
        arb_id:      sba_pkg::SBA_ID_RESET,
        rot_id:      sba_pkg::SBA_ROT_RESET,
        owner_valid: 1'b0,
        owner:       sba_pkg::SBA_ID_RESET,
        req:         1'b0,
        hold:        1'b0,
        prev_lines:  sba_pkg::SBA_LINES_IDLE,
        phase:       sba_pkg::SBA_PHASE_RESET,
        bnr_drive:   1'b0,
        stall:       1'b0
    };

    sba_sym_state_t s_q;
    sba_sym_state_t s_d;

    // resolved views of the bus, asserted-high
    logic [3:0] pins;
    logic [3:0] lines;
    logic [3:0] others;
    logic [1:0] pick;
    logic       am_owner;
    logic       evt_idle;
    logic       evt_hand;
    logic       drop;
    logic       init_seen;
    logic       prio_seen;
    logic       stall_line;
    logic [3:0] own_bit;

    // capture order pin 0, 3, 2, 1; with no pin seen fall back to id 0
    function automatic logic [1:0] id_from_pins(input logic [3:0] p);
        logic [1:0] id;
        id = sba_pkg::SBA_ID_RESET;
        if (p[0]) begin
            id = 2'h0;
        end else if (p[sba_pkg::SBA_PIN_FOR_ID1]) begin
            id = 2'h1;
        end else if (p[sba_pkg::SBA_PIN_FOR_ID2]) begin
            id = 2'h2;
        end else if (p[sba_pkg::SBA_PIN_FOR_ID3]) begin
            id = 2'h3;
        end
        return id;
    endfunction

    // bus levels are active low; work in asserted-high inside
    assign pins     = ~bus.phys_pins_n;
    assign lines    = sba_pkg::sba_map_lines(pins, s_q.arb_id);
    assign own_bit    = 4'h1 << s_q.arb_id;
    assign others     = lines & ~own_bit;
    // bus init is only honoured when the enable says so
    assign init_seen  = bus_init_signal_enable && !bus.bus_init_signal_n;
    assign prio_seen  = !bus.priority_agent_request_n;
    assign stall_line = !bus.block_next_request_n;

    // lines are indexed by agent id once the board rotation is undone
    assign am_owner = s_q.owner_valid && (s_q.owner == s_q.arb_id);
    assign evt_idle = (s_q.prev_lines == sba_pkg::SBA_LINES_IDLE)
                      && (lines != sba_pkg::SBA_LINES_IDLE);
    assign evt_hand = s_q.owner_valid && s_q.prev_lines[s_q.owner]
                      && !lines[s_q.owner];
    assign pick     = sba_pkg::sba_rr_pick(lines, s_q.rot_id);

    always_comb begin
        s_d  = s_q;
        drop = 1'b0;
        if (!s_q.id_valid) begin
            // first cycle after release: priority agent still holds line 0
            s_d.id_valid = 1'b1;
            // pins stand still through this cycle, so one look is enough
            s_d.arb_id   = id_from_pins(pins);
        end else if (init_seen) begin
            // identity survives; only bus tracking state is dropped
            s_d.rot_id      = sba_pkg::SBA_ROT_RESET;
            s_d.owner_valid = 1'b0;
            s_d.req         = 1'b0;
            s_d.hold        = 1'b0;
            s_d.prev_lines  = sba_pkg::SBA_LINES_IDLE;
            s_d.phase       = sba_pkg::SBA_PHASE_RESET;
            s_d.bnr_drive   = 1'b0;
            s_d.stall       = 1'b0;
            // limitation: drive may move again on the next drive edge
        end else begin
            s_d.phase      = ~s_q.phase;
            // last cycle's lines feed the idle and hand-over events
            s_d.prev_lines = lines;
            // drive edges and sample edges alternate so no glitch is sampled
            if (s_q.phase == sba_pkg::SBA_DRIVE_PHASE) begin
                s_d.bnr_drive = queue_full;
            end else begin
                s_d.stall = stall_line;
            end
            // every agent sees the same lines and rot id, so all pick alike
            if (evt_idle || evt_hand) begin
                if (lines != sba_pkg::SBA_LINES_IDLE) begin
                    s_d.owner       = pick;
                    s_d.rot_id      = pick;
                    s_d.owner_valid = 1'b1;
                end else begin
                    // owner left with nobody waiting: bus goes idle
                    s_d.owner_valid = 1'b0;
                end
            end
            // hold blocks a re-raise right after any drop, whatever user_req does
            s_d.hold = 1'b0;
            if (s_q.req) begin
                if (am_owner && (others != sba_pkg::SBA_LINES_IDLE)) begin
                    drop = 1'b1;
                // with PARK off the owner lets go as soon as its user does
                end else if (!user_req && !(am_owner && PARK)) begin
                    drop = 1'b1;
                end
                if (drop) begin
                    s_d.req  = 1'b0;
                    s_d.hold = 1'b1;
                end
            end else if (!s_q.hold && user_req) begin
                s_d.req = 1'b1;
            end
        end
    end

    // one register for all state keeps reset in one place
    always_ff @(posedge mclk) begin
        if (reset) begin
            s_q <= SBA_SYM_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // only pin 0 is ever driven: it carries line n for agent n
    assign bus.req_pin0_out  = 1'b0;
    assign bus.req_pin0_oe_n = ~(s_q.id_valid && s_q.req);
    assign bus.bnr_out       = 1'b0;
    assign bus.bnr_oe_n      = ~s_q.bnr_drive;

    // registered outputs straight from state
    assign id_valid    = s_q.id_valid;
    assign arb_id      = s_q.arb_id;
    assign reported_id = {s_q.arb_id, 1'b0};
    assign rot_id      = s_q.rot_id;
    assign is_owner    = s_q.id_valid && am_owner && s_q.req;
    assign stall       = s_q.stall;

    // a locked sequence may continue under priority request, never under stall
    assign issue_ok = is_owner && !s_q.stall
                      && (!prio_seen || user_locked);

endmodule

// *** hw/sba_pkg.sv ***
// shared constants and helper functions for symmetric bus arbitration
package sba_pkg;

    localparam int         SBA_NUM_AGENTS  = 4;
    localparam logic [1:0] SBA_ROT_RESET   = 2'h3;
    localparam logic [1:0] SBA_ID_RESET    = 2'h0;
    localparam logic       SBA_PHASE_RESET = 1'h0;
    localparam logic       SBA_DRIVE_PHASE = 1'h0;
    localparam logic [3:0] SBA_LINES_IDLE  = 4'h0;
    localparam int         SBA_HOLD_CYCLES = 1;

    // physical pin index that selects each arbitration id
    localparam logic [1:0] SBA_PIN_FOR_ID1 = 2'h3;
    localparam logic [1:0] SBA_PIN_FOR_ID2 = 2'h2;
    localparam logic [1:0] SBA_PIN_FOR_ID3 = 2'h1;

    // line i of the bus arrives on pin (i - k) mod 4 of agent k
    function automatic logic [3:0] sba_map_lines(input logic [3:0] pins,
                                                 input logic [1:0] k);
        logic [3:0] lines;
        lines = 4'h0;
        for (int i = 0; i < SBA_NUM_AGENTS; i++) begin
            lines[i] = pins[2'(i) - k];
        end
        return lines;
    endfunction

    // round robin: first requester after rot gets the bus
    function automatic logic [1:0] sba_rr_pick(input logic [3:0] req,
                                               input logic [1:0] rot);
        logic [1:0] idx;
        logic [1:0] pick;
        logic       found;
        pick  = rot;
        found = 1'b0;
        for (int i = 1; i <= SBA_NUM_AGENTS; i++) begin
            idx = rot + 2'(i);
            if (!found && req[idx]) begin
                pick  = idx;
                found = 1'b1;
            end
        end
        return pick;
    endfunction

endpackage

// *** hw/sba_if.sv ***
// attachment of one agent to the arbitration signals; levels are active low
`timescale 1ns/1ps
interface sba_if;
    // resolved wire levels; all but priority_agent_request_n worked out by the bench from the enables
    logic [3:0] phys_pins_n;
    logic [3:0] symmetric_request_lines_n;
    logic       block_next_request_n;
    logic       priority_agent_request_n;
    logic       bus_init_signal_n;
    // symmetric agent drives: own request on pin 0, stall line
    logic       req_pin0_out;
    logic       req_pin0_oe_n;
    logic       bnr_out;
    logic       bnr_oe_n;
    // priority agent drives
    logic       pr_br0_out;
    logic       pr_br0_oe_n;
    logic       pr_bnr_out;
    logic       pr_bnr_oe_n;
    logic       pr_bus_init_signal_out;
    logic       pr_bus_init_signal_oe_n;

    modport sym_mp (
        input  phys_pins_n,
        input  block_next_request_n,
        input  priority_agent_request_n,
        input  bus_init_signal_n,
        output req_pin0_out,
        output req_pin0_oe_n,
        output bnr_out,
        output bnr_oe_n
    );

    modport prio_mp (
        input  symmetric_request_lines_n,
        input  block_next_request_n,
        input  bus_init_signal_n,
        output priority_agent_request_n,
        output pr_br0_out,
        output pr_br0_oe_n,
        output pr_bnr_out,
        output pr_bnr_oe_n,
        output pr_bus_init_signal_out,
        output pr_bus_init_signal_oe_n
    );
endinterface

// *** hw/sba_prio_agent.sv ***
// priority agent end: bus request, reset-time line 0 drive, stall and bus init
`timescale 1ns/1ps
module sba_prio_agent #(
    parameter int OUT_W = 4
) (
    input  wire logic             mclk,
    input  wire logic             reset,
    sba_if.prio_mp                bus,
    input  wire logic             pr_want,
    input  wire logic [OUT_W-1:0] pr_outstanding,
    input  wire logic             queue_full,
    input  wire logic             bus_error,
    output logic                  pr_bus_held,
    output logic                  stall,
    output logic                  issue_ok
);

    typedef struct packed {
        logic cfg;
        logic priority_agent_request;
        logic phase;
        logic bnr_drive;
        logic stall;
        logic bus_init_signal;
    } sba_prio_state_t;

    localparam sba_prio_state_t SBA_PRIO_RESET = '{
        cfg:       1'b1,
        priority_agent_request:      1'b0,
        phase:     sba_pkg::SBA_PHASE_RESET,
        bnr_drive: 1'b0,
        stall:     1'b0,
        bus_init_signal:     1'b0
    };

    sba_prio_state_t s_q;
    sba_prio_state_t s_d;

    always_comb begin
        s_d       = s_q;
        // line 0 stays asserted through the edge that samples identities
        s_d.cfg   = 1'b0;
        s_d.bus_init_signal = bus_error;
        // release only once every outstanding request has completed
        s_d.priority_agent_request  = pr_want || (pr_outstanding != '0);
        if (!bus.bus_init_signal_n) begin
            s_d.phase     = sba_pkg::SBA_PHASE_RESET;
            s_d.bnr_drive = 1'b0;
            s_d.stall     = 1'b0;
        end else begin
            s_d.phase = ~s_q.phase;
            if (s_q.phase == sba_pkg::SBA_DRIVE_PHASE) begin
                s_d.bnr_drive = queue_full;
            end else begin
                s_d.stall = !bus.block_next_request_n;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            s_q <= SBA_PRIO_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.priority_agent_request_n = ~s_q.priority_agent_request;
    assign bus.pr_br0_out               = 1'b0;
    assign bus.pr_br0_oe_n              = ~s_q.cfg;
    assign bus.pr_bnr_out               = 1'b0;
    assign bus.pr_bnr_oe_n              = ~s_q.bnr_drive;
    assign bus.pr_bus_init_signal_out             = 1'b0;
    assign bus.pr_bus_init_signal_oe_n            = ~s_q.bus_init_signal;

    assign pr_bus_held = s_q.priority_agent_request;
    assign stall       = s_q.stall;
    assign issue_ok    = s_q.priority_agent_request && pr_want && !s_q.stall;

endmodule

// *** tb/sba_asserts.sv ***
// wire checks around agent 0 and the priority agent
`timescale 1ns/1ps
module sba_asserts (
    input wire logic       mclk,
    input wire logic       reset,
    input wire logic [3:0] phys_pins_n,
    input wire logic [3:0] symmetric_request_lines_n,
    input wire logic       bus_init_signal_n,
    input wire logic       req_pin0_oe_n,
    input wire logic       bnr_oe_n,
    input wire logic       pr_br0_oe_n,
    input wire logic       pr_bnr_oe_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    sequence s_cfg;
        !pr_br0_oe_n && phys_pins_n == 4'he;
    endsequence
    sequence s_alone;
        !req_pin0_oe_n && symmetric_request_lines_n == 4'he && bus_init_signal_n;
    endsequence
    a_cfg_line_zero: assert property ($fell(reset) |-> s_cfg ##[1:2] pr_br0_oe_n)
        else $error("line 0 not driven for configuration");
    a_line0_reset_only: assert property (!pr_br0_oe_n |-> $past(reset) || $past(reset, 2))
        else $error("line 0 driven after configuration");
    a_no_early_req: assert property ($fell(reset) |-> req_pin0_oe_n [*2])
        else $error("request before identity capture");
    a_stall_edges: assert property ($changed(bnr_oe_n) |=> $stable(bnr_oe_n))
        else $error("stall drive moved on two edges in a row");
    a_prio_stall_edges: assert property ($changed(pr_bnr_oe_n) |=> $stable(pr_bnr_oe_n))
        else $error("priority stall drive moved on two edges in a row");
    a_init_drop: assert property (!bus_init_signal_n |=> req_pin0_oe_n)
        else $error("request kept through bus init");
    a_drop_hold: assert property ($rose(req_pin0_oe_n) |=> req_pin0_oe_n)
        else $error("request raised right after a drop");
    a_park_owner: assert property (s_alone [*2] |=> !req_pin0_oe_n)
        else $error("lone owner gave up the bus");
endmodule

// *** tb/symmetric_bus_arbitration_tb.sv ***
// bench: four symmetric agents and the priority agent on one bus
`timescale 1ns/1ps
module symmetric_bus_arbitration_tb;
    logic       mclk, reset, pwant, pqf, berr, pheld, pstl, piok, bnr_n;
    logic [3:0] ureq, ulck, qf, pout, lines_n, bnr_v, own_v, iok_v, stl_v, idv, r, om;
    logic [1:0] re, aid [4], rot [4];
    logic [2:0] rid [4];
    logic [7:0] exp_q [$];
    int         sel = -1, n_errors = 0, check_count = 0, p;
    sba_if sif[4] ();
    sba_if pif ();
    assign bnr_n = &bnr_v & pif.pr_bnr_oe_n;
    assign pif.symmetric_request_lines_n = lines_n;
    assign pif.block_next_request_n = bnr_n;
    assign pif.bus_init_signal_n = pif.pr_bus_init_signal_oe_n;
    for (genvar k = 0; k < 4; k++) begin : g_agent
        assign lines_n[k] = sif[k].req_pin0_oe_n & (k != 0 || pif.pr_br0_oe_n);
        assign bnr_v[k] = sif[k].bnr_oe_n;
        // board rotation: pin p of agent k sits on line (p + k) mod 4
        assign sif[k].phys_pins_n = {lines_n[(k+3)%4], lines_n[(k+2)%4],
                                     lines_n[(k+1)%4], lines_n[k]};
        assign sif[k].block_next_request_n = bnr_n;
        assign sif[k].priority_agent_request_n = pif.priority_agent_request_n;
        assign sif[k].bus_init_signal_n = pif.pr_bus_init_signal_oe_n;
        sba_sym_agent sba_sym_agent_inst (.mclk(mclk), .reset(reset), .bus(sif[k]),
            .bus_init_signal_enable(1'b1), .user_req(ureq[k]), .user_locked(ulck[k]),
            .queue_full(qf[k]), .id_valid(idv[k]), .arb_id(aid[k]), .reported_id(rid[k]),
            .rot_id(rot[k]), .is_owner(own_v[k]), .stall(stl_v[k]), .issue_ok(iok_v[k]));
    end
    sba_prio_agent sba_prio_agent_inst (.mclk(mclk), .reset(reset), .bus(pif),
        .pr_want(pwant), .pr_outstanding(pout), .queue_full(pqf), .bus_error(berr),
        .pr_bus_held(pheld), .stall(pstl), .issue_ok(piok));
    sba_asserts sba_asserts_inst (.mclk(mclk), .reset(reset),
        .phys_pins_n(sif[0].phys_pins_n), .symmetric_request_lines_n(lines_n),
        .bus_init_signal_n(pif.bus_init_signal_n), .req_pin0_oe_n(sif[0].req_pin0_oe_n),
        .bnr_oe_n(sif[0].bnr_oe_n), .pr_br0_oe_n(pif.pr_br0_oe_n),
        .pr_bnr_oe_n(pif.pr_bnr_oe_n));

    function automatic logic [7:0] obs(input int s);
        case (s)
            0: return {own_v, rot[0], rot[3]};
            1: return {pstl, stl_v, 3'h0};
            2: return {pheld, piok, 2'h0, iok_v};
            default: return {idv[s-3], rid[s-3], aid[s-3], rot[s-3]};
        endcase
    endfunction

    function automatic logic [1:0] rr_next(input logic [3:0] m, input logic [1:0] from);
        for (int i = 1; i <= 4; i++)
            if (m[2'(from + i)]) return 2'(from + i);
        return from;
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        check_count++;
        if (seen !== want) begin
            n_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic note(input int s, input logic [7:0] e);
        exp_q.push_back(e);
        sel = s;
        tick(1);
    endtask

    always @(posedge mclk)
        if (sel >= 0) begin
            check(obs(sel), exp_q.pop_front());
            sel <= -1;
        end

    task automatic do_reset();
        reset = 1'b1;
        tick(4);
        reset = 1'b0;
        tick(3);
        for (int k = 0; k < 4; k++)
            note(3 + k, {1'b1, 3'(2 * k), 2'(k), 2'h3});
        {om, re} = 6'h03;
        $display("test reset and identity done");
    endtask

    // requesters never include the parked owner, so one hand-over is predictable
    task automatic round(input logic [3:0] m);
        int n;
        r = m & ~om;
        if (r == 4'h0) r = {om[2:0], om[3]};
        p = rr_next(r, re);
        ureq = r;
        n = 0;
        while ((own_v == 4'h0 || (own_v & om) != 4'h0) && n < 40) begin
            tick(1);
            n++;
        end
        ureq = 4'h0;
        note(0, {4'h1 << p, 2'(p), 2'(p)});
        tick(6);
        om = (r == (4'h1 << p)) ? r : 4'h0;
        re = 2'(p);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // whole run needs about 200 cycles
    initial begin
        #40000;
        n_errors++;
        print_verdict();
    end

    initial begin
        {ureq, ulck, qf, pout, pwant, pqf, berr} = '0;
        reset = 1'b1;
        void'($urandom(15246));
        tick(1);
        do_reset();
        repeat (8) round(4'($urandom_range(1, 15)));
        $display("test round robin done");
        berr = 1'b1;
        tick(1);
        berr = 1'b0;
        tick(5);
        note(0, 8'h0f);
        {om, re} = 6'h03;
        round(4'h1);
        $display("test bus init done");
        for (int i = 0; i < 2; i++) begin
            qf = i ? 4'h0 : 4'($urandom_range(0, 15)) | 4'h1;
            pqf = 1'(i);
            tick(5);
            note(1, 8'hf8);
            note(2, 8'h00);
            {qf, pqf} = '0;
            tick(5);
            note(1, 8'h00);
        end
        $display("test stall done");
        note(2, 8'h01);
        pwant = 1'b1;
        tick(3);
        note(2, 8'hc0);
        ulck = 4'h1;
        tick(1);
        note(2, 8'hc1);
        {pwant, ulck} = '0;
        pout = 4'($urandom_range(1, 15));
        tick(4);
        note(2, 8'h80);
        pout = 4'h0;
        tick(3);
        note(2, 8'h01);
        $display("test priority done");
        do_reset();
        print_verdict();
    end
endmodule
